// file: core/pbc_pkg.sv
/*
  Constants and state types for the programming-port boot control block.
  Assumes a 200 MHz system clock shared by every user of the package.
*/
package pbc_pkg;
  localparam int unsigned PBC_CLK_HZ    = 200_000_000;
  localparam int unsigned PBC_BAUD_BPS  = 2400;
  // Cycles per serial bit, nominal period rounded down
  localparam int unsigned PBC_BIT_CYC   = PBC_CLK_HZ / PBC_BAUD_BPS;
  // Cycles the raised transmit line settles before the loop-back is read
  localparam int unsigned PBC_PROBE_CYC = 4;
  localparam logic [7:0]  PBC_SEQ_B0    = 8'h80;
  localparam logic [7:0]  PBC_SEQ_B1    = 8'h24;
  localparam logic [7:0]  PBC_SEQ_B2    = 8'h80;
  localparam logic [1:0]  PBC_SEQ_LAST  = 2'h2;
  localparam logic [2:0]  PBC_LAST_BIT  = 3'h7;

  typedef enum logic [1:0]
  {
    PBC_ST_SENSE = 2'b00,
    PBC_ST_RUN   = 2'b01,
    PBC_ST_HOLD  = 2'b10
  } pbc_boot_st_t;

  typedef enum logic [1:0]
  {
    PBC_RX_IDLE  = 2'b00,
    PBC_RX_START = 2'b01,
    PBC_RX_DATA  = 2'b10,
    PBC_RX_STOP  = 2'b11
  } pbc_rx_st_t;
endpackage

// file: core/pbc_sync.sv
/*
  Two-stage synchroniser for a bundle of asynchronous pin levels.
  Assumes one clock and a synchronous active-low reset.
*/
`timescale 1ns/1ps
module pbc_sync #(
  parameter int unsigned      WIDTH   = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input  wire logic             i_clk,
  input  wire logic             i_nrst,
  input  wire logic [WIDTH-1:0] i_async,
  output logic      [WIDTH-1:0] o_sync
);
  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] sync_reg;

  always_ff @(posedge i_clk)
  begin
    if (!i_nrst)
    begin
      meta_reg <= RST_VAL;
      sync_reg <= RST_VAL;
    end
    else
    begin
      meta_reg <= i_async;
      sync_reg <= meta_reg;
    end
  end

  assign o_sync = sync_reg;
endmodule

// file: core/pbc_boot_ctrl.sv
/*
  Device-side boot and restart control behind the programming port:
  reset line, boot-mode sensing, restart byte detection, transmit line.
  Assumes pins are asynchronous; mode inputs come from local logic.
*/
`timescale 1ns/1ps
module pbc_boot_ctrl
  import pbc_pkg::*;
#(
  parameter int unsigned P_BIT_CYCLES = PBC_BIT_CYC
) (
  input  wire logic       I_SYS_CLK,
  input  wire logic       I_NRST,
  input  wire logic       I_PROGRAMMING_CONNECTOR_RESET_N,
  input  wire logic       I_BOOT_SELECT_PIN0,
  input  wire logic       I_BOOT_SELECT_PIN1,
  input  wire logic       I_DIAGNOSTIC_CONNECTOR_CONNECTOR,
  input  wire logic       I_PORT_A_RECEIVE,
  input  wire logic       I_PORT_A_RECEIVE_DRIVEN,
  input  wire logic       I_PORT_A_SERIAL_CLOCK,
  input  wire logic       I_PORT_A_SERIAL_CLOCK_DRIVEN,
  input  wire logic       I_CLOCKED_MODE,
  input  wire logic       I_COLD_BOOT_EN,
  input  wire logic       I_CABLE_PROBE,
  output logic            O_TARGET_RESET,
  output logic            O_BOOT_RESTART,
  output logic            O_BOOTSTRAP_MODE,
  output logic            O_PROGRAMMING_CONNECTOR_STATUS,
  output logic      [7:0] O_RX_DATA,
  output logic            O_RX_VALID,
  output logic            O_PORT_A_TRANSMIT,
  output logic            O_CABLE_DETECT
);
  localparam int unsigned CW = $clog2(P_BIT_CYCLES + 1);
  localparam logic [CW-1:0] FULL_M1 = CW'(P_BIT_CYCLES - 1);
  localparam logic [CW-1:0] HALF_M1 = CW'(P_BIT_CYCLES / 2 - 1);
  localparam logic [2:0] PROBE_M1 = 3'(PBC_PROBE_CYC - 1);
  // Edges after reset before the synchronised pins show real levels
  localparam logic [1:0] SETTLE_LAST = 2'h2;

  if (P_BIT_CYCLES < 4)
  begin : g_chk
    $error("P_BIT_CYCLES must be at least 4");
  end

  // Pull-ups: an undriven receive or serial clock pin reads high
  logic [5:0] pin_async;
  logic [5:0] pin_s;
  assign pin_async = {I_DIAGNOSTIC_CONNECTOR_CONNECTOR,
                      I_PORT_A_SERIAL_CLOCK_DRIVEN ? I_PORT_A_SERIAL_CLOCK
                                                   : 1'b1,
                      I_PORT_A_RECEIVE_DRIVEN ? I_PORT_A_RECEIVE
                                              : 1'b1,
                      I_BOOT_SELECT_PIN1, I_BOOT_SELECT_PIN0, I_PROGRAMMING_CONNECTOR_RESET_N};

  pbc_sync #(.WIDTH(6), .RST_VAL(6'h1E)) u_sync (
    .i_clk   (I_SYS_CLK),
    .i_nrst  (I_NRST),
    .i_async (pin_async),
    .o_sync  (pin_s)
  );

  logic prst_n_s;
  logic sel0_s;
  logic sel1_s;
  logic rx_s;
  logic sclk_s;
  logic diagnostic_connector_s;
  assign prst_n_s = pin_s[0];
  assign sel0_s   = pin_s[1];
  assign sel1_s   = pin_s[2];
  assign rx_s     = pin_s[3];
  assign sclk_s   = pin_s[4];
  assign diagnostic_connector_s   = pin_s[5];

  // Receive path state
  pbc_rx_st_t    rx_st_reg,  rx_st_next;
  logic [CW-1:0] cnt_reg,    cnt_next;
  logic [2:0]    bit_reg,    bit_next;
  logic [7:0]    sh_reg,     sh_next;
  logic [7:0]    data_reg,   data_next;
  logic          valid_reg,  valid_next;
  logic          sclk_d_reg, sclk_d_next;
  logic [1:0]    seq_reg,    seq_next;
  logic          match_reg,  match_next;

  // Boot control state
  pbc_boot_st_t  st_reg,     st_next;
  logic [1:0]    wake_reg,   wake_next;
  logic          boot_reg,   boot_next;
  logic          trst_reg,   trst_next;
  logic          rstrt_reg,  rstrt_next;
  logic          stat_reg,   stat_next;

  // Transmit and cable probe state
  logic          tx_reg,     tx_next;
  logic [2:0]    pcnt_reg,   pcnt_next;
  logic          det_reg,    det_next;

  logic [7:0] exp_byte;
  always_comb
  begin
    exp_byte = PBC_SEQ_B0;
    if (seq_reg == 2'h1)
      exp_byte = PBC_SEQ_B1;
    else if (seq_reg == PBC_SEQ_LAST)
      exp_byte = PBC_SEQ_B2;
  end

  always_comb
  begin
    rx_st_next  = rx_st_reg;
    cnt_next    = cnt_reg;
    bit_next    = bit_reg;
    sh_next     = sh_reg;
    data_next   = data_reg;
    valid_next  = 1'b0;
    sclk_d_next = sclk_s;
    seq_next    = seq_reg;
    match_next  = 1'b0;
    if (st_reg != PBC_ST_RUN)
    begin
      // Nothing is received while the target is held or re-sensing
      rx_st_next = PBC_RX_IDLE;
      bit_next   = 3'h0;
      seq_next   = 2'h0;
    end
    else if (I_CLOCKED_MODE)
    begin
      rx_st_next = PBC_RX_IDLE;
      if (sclk_s && !sclk_d_reg)
      begin
        // Partner raises the clock line; data sampled LSB first
        sh_next  = {rx_s, sh_reg[7:1]};
        bit_next = bit_reg + 3'h1;
        if (bit_reg == PBC_LAST_BIT)
        begin
          data_next  = {rx_s, sh_reg[7:1]};
          valid_next = 1'b1;
        end
      end
    end
    else
    begin
      case (rx_st_reg)
        PBC_RX_IDLE:
        begin
          cnt_next = '0;
          bit_next = 3'h0;
          if (!rx_s)
            rx_st_next = PBC_RX_START;
        end
        PBC_RX_START:
        begin
          cnt_next = cnt_reg + CW'(1);
          if (cnt_reg == HALF_M1)
          begin
            cnt_next   = '0;
            rx_st_next = rx_s ? PBC_RX_IDLE : PBC_RX_DATA;
          end
        end
        PBC_RX_DATA:
        begin
          cnt_next = cnt_reg + CW'(1);
          if (cnt_reg == FULL_M1)
          begin
            cnt_next = '0;
            sh_next  = {rx_s, sh_reg[7:1]};
            bit_next = bit_reg + 3'h1;
            if (bit_reg == PBC_LAST_BIT)
              rx_st_next = PBC_RX_STOP;
          end
        end
        default:
        begin
          cnt_next = cnt_reg + CW'(1);
          if (cnt_reg == FULL_M1)
          begin
            rx_st_next = PBC_RX_IDLE;
            data_next  = sh_reg;
            valid_next = rx_s;
          end
        end
      endcase
    end
    if (valid_reg && st_reg == PBC_ST_RUN)
    begin
      // Track 80h 24h 80h; a stray 80h restarts the match
      if (data_reg == exp_byte)
      begin
        seq_next = seq_reg + 2'h1;
        if (seq_reg == PBC_SEQ_LAST)
        begin
          seq_next   = 2'h0;
          match_next = 1'b1;
        end
      end
      else
        seq_next = (data_reg == PBC_SEQ_B0) ? 2'h1 : 2'h0;
    end
  end

  always_ff @(posedge I_SYS_CLK)
  begin
    if (!I_NRST)
    begin
      rx_st_reg  <= PBC_RX_IDLE;
      cnt_reg    <= '0;
      bit_reg    <= 3'h0;
      sh_reg     <= 8'h00;
      data_reg   <= 8'h00;
      valid_reg  <= 1'b0;
      sclk_d_reg <= 1'b1;
      seq_reg    <= 2'h0;
      match_reg  <= 1'b0;
    end
    else
    begin
      rx_st_reg  <= rx_st_next;
      cnt_reg    <= cnt_next;
      bit_reg    <= bit_next;
      sh_reg     <= sh_next;
      data_reg   <= data_next;
      valid_reg  <= valid_next;
      sclk_d_reg <= sclk_d_next;
      seq_reg    <= seq_next;
      match_reg  <= match_next;
    end
  end

  always_comb
  begin
    st_next    = st_reg;
    wake_next  = wake_reg;
    boot_next  = boot_reg;
    trst_next  = 1'b0;
    rstrt_next = 1'b0;
    case (st_reg)
      PBC_ST_SENSE:
      begin
        // Synchroniser reset values must not be taken as pin levels
        if (wake_reg != SETTLE_LAST)
          wake_next = wake_reg + 2'h1;
        else
        begin
          // Diagnostic connector leaves boot pins open
          boot_next = sel0_s && sel1_s && !diagnostic_connector_s;
          st_next   = PBC_ST_RUN;
        end
      end
      PBC_ST_RUN:
      begin
        if (!prst_n_s && !diagnostic_connector_s)
        begin
          st_next   = PBC_ST_HOLD;
          trst_next = 1'b1;
        end
        else if (match_reg)
        begin
          rstrt_next = 1'b1;
          st_next    = PBC_ST_SENSE;
        end
      end
      default:
      begin
        trst_next = !prst_n_s;
        if (prst_n_s)
          st_next = PBC_ST_SENSE;
      end
    endcase
    stat_next = (st_next == PBC_ST_RUN);
  end

  always_ff @(posedge I_SYS_CLK)
  begin
    if (!I_NRST)
    begin
      st_reg    <= PBC_ST_SENSE;
      wake_reg  <= 2'h0;
      boot_reg  <= 1'b0;
      trst_reg  <= 1'b0;
      rstrt_reg <= 1'b0;
      stat_reg  <= 1'b0;
    end
    else
    begin
      st_reg    <= st_next;
      wake_reg  <= wake_next;
      boot_reg  <= boot_next;
      trst_reg  <= trst_next;
      rstrt_reg <= rstrt_next;
      stat_reg  <= stat_next;
    end
  end

  always_comb
  begin
    // Low unless cold boot keeps it idle-high or the probe raises it
    tx_next   = I_COLD_BOOT_EN || I_CABLE_PROBE;
    pcnt_next = 3'h0;
    det_next  = det_reg;
    if (!I_COLD_BOOT_EN && I_CABLE_PROBE)
    begin
      pcnt_next = (pcnt_reg == PROBE_M1) ? pcnt_reg : pcnt_reg + 3'h1;
      if (pcnt_reg == PROBE_M1)
        det_next = sel0_s;
    end
  end

  always_ff @(posedge I_SYS_CLK)
  begin
    if (!I_NRST)
    begin
      tx_reg   <= 1'b0;
      pcnt_reg <= 3'h0;
      det_reg  <= 1'b0;
    end
    else
    begin
      tx_reg   <= tx_next;
      pcnt_reg <= pcnt_next;
      det_reg  <= det_next;
    end
  end

  assign O_TARGET_RESET    = trst_reg;
  assign O_BOOT_RESTART    = rstrt_reg;
  assign O_BOOTSTRAP_MODE  = boot_reg;
  assign O_PROGRAMMING_CONNECTOR_STATUS     = stat_reg;
  assign O_RX_DATA         = data_reg;
  assign O_RX_VALID        = valid_reg;
  assign O_PORT_A_TRANSMIT = tx_reg;
  assign O_CABLE_DETECT    = det_reg;

  default clocking cb @(posedge I_SYS_CLK);
  endclocking
  default disable iff (!I_NRST);

  a_reset_hold: assert property (
    (st_reg == PBC_ST_RUN && !prst_n_s && !diagnostic_connector_s) |=> trst_reg
  ) else $error("Reset line did not hold the target");

  a_status_run: assert property (
    (st_reg == PBC_ST_SENSE && wake_reg == SETTLE_LAST) |=> stat_reg
  ) else $error("Status not shown after sensing");

  a_boot_sense: assert property (
    (st_reg == PBC_ST_SENSE && wake_reg == SETTLE_LAST)
      |=> (boot_reg == $past(sel0_s && sel1_s && !diagnostic_connector_s))
  ) else $error("Bootstrap mode not taken from boot pins");

  a_seq_restart: assert property (
    rstrt_reg |-> $past(match_reg) && $past(data_reg, 2) == PBC_SEQ_B2
  ) else $error("Restart without the byte sequence");

  a_restart_pulse: assert property (
    rstrt_reg |=> !rstrt_reg ##1 (st_reg == PBC_ST_RUN)
  ) else $error("Restart not a single pulse");

  a_diagnostic_connector_no_reset: assert property (
    (diagnostic_connector_s && st_reg == PBC_ST_RUN) |=> !trst_reg
  ) else $error("Diagnostic connector reset the target");

  a_pullup_idle: assert property (
    (!I_PORT_A_RECEIVE_DRIVEN)[*3] |-> rx_s
  ) else $error("Undriven receive pin not high");

  a_tx_low: assert property (
    (!I_COLD_BOOT_EN && !I_CABLE_PROBE) |=> !O_PORT_A_TRANSMIT
  ) else $error("Transmit not low without cold boot");

  a_probe_detect: assert property (
    (!I_COLD_BOOT_EN && I_CABLE_PROBE && pcnt_reg == PROBE_M1)
      |=> O_PORT_A_TRANSMIT && O_CABLE_DETECT == $past(sel0_s)
  ) else $error("Cable probe result wrong");

  a_rx_held: assert property (
    (st_reg == PBC_ST_HOLD) |=> !match_reg ##1 !rstrt_reg
  ) else $error("Bytes taken while target held");

  c_restart: cover property (rstrt_reg);
  c_hold:    cover property (st_reg == PBC_ST_HOLD ##[1:20]
                             st_reg == PBC_ST_RUN);
  c_boot:    cover property (boot_reg && stat_reg);
  c_detect:  cover property (O_CABLE_DETECT);
endmodule

// file: verif/pbc_host_model.sv
/*
  Host serial controller and cable behind the programming connector.
  Assumes the device clock; bit time is given in clock cycles.
*/
`timescale 1ns/1ps
module pbc_host_model #(
  parameter int unsigned P_BIT = 16
) (
  input  wire logic i_clk,
  input  wire logic i_tx,
  input  wire logic i_status,
  output logic      o_reset_n,
  output logic      o_rx,
  output logic      o_rx_drv,
  output logic      o_sclk,
  output logic      o_sclk_drv,
  output logic      o_pin0,
  output logic      o_pin1
);
  logic rx_v  = 1'b1;
  logic rx_d  = 1'b0;
  logic ck_v  = 1'b1;
  logic ck_d  = 1'b0;
  logic noise = 1'b0;
  logic float_on = 1'b0;
  logic cable = 1'b0;
  logic loop  = 1'b0;
  logic dtr_n = 1'b1;
  logic dsr_seen = 1'b0;

  // Released lines show their pull-up, or noise when floating is asked
  always @(posedge i_clk)
  begin
    noise      <= ~noise;
    o_reset_n  <= dtr_n;
    o_rx       <= rx_d ? rx_v : (float_on ? noise : 1'b1);
    o_rx_drv   <= rx_d;
    o_sclk     <= ck_d ? ck_v : (float_on ? ~noise : 1'b1);
    o_sclk_drv <= ck_d;
    o_pin0     <= cable & (loop ? i_tx : 1'b1);
    o_pin1     <= cable;
    dsr_seen   <= i_status;
  end

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge i_clk);
  endtask

  task automatic restart(input int n_low, input int n_gap);
    dtr_n <= 1'b0;
    wait_cyc(n_low);
    dtr_n <= 1'b1;
    wait_cyc(n_gap);
  endtask

  task automatic send_byte(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++)
    begin
      rx_d <= 1'b1;
      rx_v <= f[i];
      wait_cyc(P_BIT);
    end
    rx_d <= 1'b0;
  endtask

  // Clock idles released high, so each bit is a low then a rising edge
  task automatic send_clocked(input logic [7:0] b);
    for (int i = 0; i < 8; i++)
    begin
      rx_d <= 1'b1;
      rx_v <= b[i];
      ck_d <= 1'b1;
      ck_v <= 1'b0;
      wait_cyc(4);
      ck_v <= 1'b1;
      wait_cyc(4);
    end
    rx_d <= 1'b0;
    ck_d <= 1'b0;
  endtask
endmodule

// file: verif/programming_port_boot_control_tb.sv
/*
  Self-checking bench for the boot control block.
  Assumes the host model drives the cable side; short bit time.
*/
`timescale 1ns/1ps
module programming_port_boot_control_tb;
  localparam int BIT = 16;
  logic       sys_clk, nrst, diagnostic_connector, clk_mode, cold_en, probe;
  logic       prst_n, pin0, pin1, rx, rx_drv, sclk, sclk_drv;
  logic       t_reset, restart, bstrap, status, rx_valid, tx, det;
  logic [7:0] rx_data, last_byte;
  int         error_cnt = 0, total_checks = 0, n_valid = 0, n_rs = 0;

  pbc_host_model #(.P_BIT(BIT)) pbc_host_model_i (
    .i_clk(sys_clk), .i_tx(tx), .i_status(status),
    .o_reset_n(prst_n), .o_rx(rx), .o_rx_drv(rx_drv), .o_sclk(sclk),
    .o_sclk_drv(sclk_drv), .o_pin0(pin0), .o_pin1(pin1));

  pbc_boot_ctrl #(.P_BIT_CYCLES(BIT)) pbc_boot_ctrl_i (
    .I_SYS_CLK(sys_clk), .I_NRST(nrst), .I_PROGRAMMING_CONNECTOR_RESET_N(prst_n),
    .I_BOOT_SELECT_PIN0(pin0), .I_BOOT_SELECT_PIN1(pin1),
    .I_DIAGNOSTIC_CONNECTOR_CONNECTOR(diagnostic_connector), .I_PORT_A_RECEIVE(rx),
    .I_PORT_A_RECEIVE_DRIVEN(rx_drv), .I_PORT_A_SERIAL_CLOCK(sclk),
    .I_PORT_A_SERIAL_CLOCK_DRIVEN(sclk_drv), .I_CLOCKED_MODE(clk_mode),
    .I_COLD_BOOT_EN(cold_en), .I_CABLE_PROBE(probe),
    .O_TARGET_RESET(t_reset), .O_BOOT_RESTART(restart),
    .O_BOOTSTRAP_MODE(bstrap), .O_PROGRAMMING_CONNECTOR_STATUS(status),
    .O_RX_DATA(rx_data), .O_RX_VALID(rx_valid),
    .O_PORT_A_TRANSMIT(tx), .O_CABLE_DETECT(det));

  initial
  begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  // Counts one-cycle pulses and keeps the last byte
  always @(posedge sys_clk)
  begin
    if (rx_valid === 1'b1)
    begin
      n_valid++;
      last_byte = rx_data;
    end
    if (restart === 1'b1)
      n_rs++;
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic final_report;
    $display("checks=%0d errors=%0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic t_reset_line;
    for (int c = 1; c >= 0; c--)
    begin
      pbc_host_model_i.cable <= c[0];
      pbc_host_model_i.dtr_n <= 1'b0;
      cyc(8);
      check(8'(t_reset), 8'h01);
      check(8'(pbc_host_model_i.dsr_seen), 8'h00);
      pbc_host_model_i.dtr_n <= 1'b1;
      cyc(8);
      check(8'(t_reset), 8'h00);
      check(8'(status), 8'h01);
      check(8'(bstrap), 8'(c));
    end
  endtask

  task automatic t_diagnostic_connector;
    diagnostic_connector <= 1'b1;
    cyc(4);
    pbc_host_model_i.dtr_n <= 1'b0;
    cyc(8);
    check(8'(t_reset), 8'h00);
    pbc_host_model_i.dtr_n <= 1'b1;
    cyc(4);
    diagnostic_connector <= 1'b0;
    cyc(4);
  endtask

  task automatic seq(input logic [7:0] b [4], input int n, input int rs);
    int v0, r0;
    v0 = n_valid;
    r0 = n_rs;
    for (int i = 0; i < n; i++)
    begin
      pbc_host_model_i.send_byte(b[i]);
      cyc(8);
      check(last_byte, b[i]);
    end
    cyc(6);
    check(8'(n_valid - v0), 8'(n));
    check(8'(n_rs - r0), 8'(rs));
  endtask

  task automatic t_seq;
    pbc_host_model_i.restart(8, 8);
    seq('{8'h80, 8'h24, 8'h80, 8'h00}, 3, 1);
    seq('{8'h80, 8'h80, 8'h24, 8'h80}, 4, 1);
    seq('{8'h80, 8'h24, 8'h81, 8'h00}, 3, 0);
    seq('{8'h24, 8'h80, 8'h80, 8'h00}, 3, 0);
  endtask

  task automatic t_held;
    int v0, r0;
    v0 = n_valid;
    r0 = n_rs;
    pbc_host_model_i.dtr_n <= 1'b0;
    cyc(6);
    pbc_host_model_i.send_byte(8'h80);
    pbc_host_model_i.send_byte(8'h24);
    pbc_host_model_i.send_byte(8'h80);
    pbc_host_model_i.restart(1, 8);
    check(8'(n_valid - v0), 8'h00);
    check(8'(n_rs - r0), 8'h00);
  endtask

  task automatic t_clocked;
    int v0;
    v0 = n_valid;
    clk_mode <= 1'b1;
    pbc_host_model_i.send_clocked(8'hA5);
    cyc(6);
    check(last_byte, 8'hA5);
    check(8'(n_valid - v0), 8'h01);
    clk_mode <= 1'b0;
  endtask

  task automatic t_float;
    int v0;
    v0 = n_valid;
    pbc_host_model_i.float_on <= 1'b1;
    cyc(BIT * 24);
    clk_mode <= 1'b1;
    cyc(BIT * 8);
    clk_mode <= 1'b0;
    pbc_host_model_i.float_on <= 1'b0;
    check(8'(n_valid - v0), 8'h00);
  endtask

  task automatic t_tx_probe;
    check(8'(tx), 8'h00);
    cold_en <= 1'b1;
    cyc(3);
    check(8'(tx), 8'h01);
    cold_en <= 1'b0;
    pbc_host_model_i.cable <= 1'b1;
    pbc_host_model_i.loop <= 1'b1;
    probe <= 1'b1;
    cyc(12);
    check(8'(tx), 8'h01);
    check(8'(det), 8'h01);
    pbc_host_model_i.cable <= 1'b0;
    cyc(10);
    check(8'(det), 8'h00);
    probe <= 1'b0;
    cyc(3);
    check(8'(tx), 8'h00);
  endtask

  initial
  begin
    nrst = 1'b0;
    diagnostic_connector = 1'b0;
    clk_mode = 1'b0;
    cold_en = 1'b0;
    probe = 1'b0;
    cyc(10);
    nrst <= 1'b1;
    cyc(4);
    check(8'(status), 8'h01);
    check(8'(t_reset), 8'h00);
    t_reset_line;
    t_diagnostic_connector;
    t_seq;
    t_held;
    t_clocked;
    t_float;
    t_tx_probe;
    final_report;
  end

  initial
  begin
    cyc(20000);
    error_cnt++;
    final_report;
  end
endmodule
